// [hw/sac_params.svh]
// Constants for the successive-approximation converter control block.
// Assumes inclusion by bare name from design files under hw/.
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH
// ----------------------------------------------------------------------
// Register offsets (plain register port, 4-bit address)
// ----------------------------------------------------------------------
`define SAC_OFS_CTRL0 4'h0
`define SAC_OFS_CTRL1 4'h1
`define SAC_OFS_RESULT 4'h2
`define SAC_OFS_IRQ_STAT 4'h3
`define SAC_OFS_IRQ_MASK 4'h4
`define SAC_OFS_MODE 4'h5
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SAC_CTRL0_ON_BIT 0
`define SAC_CTRL0_GO_BIT 1
`define SAC_CTRL0_CHS_LSB 2
`define SAC_CTRL1_REF_LSB 0
`define SAC_CTRL1_CS_LSB 4
`define SAC_MODE_SLEEP_BIT 0
// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define SAC_RST_BYTE 8'h00
`define SAC_CHS_RESERVED 4'hE
`define SAC_CHS_FIXED_REF 4'hF
`define SAC_REF_EXT 2'h2
`define SAC_REF_FIXED 2'h3
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SAC_BIT_PERIODS 4'hA
`define SAC_CLK_HZ 25000000
// RC oscillator bit period, typical figure in nanoseconds
`define SAC_RC_PERIOD_NS 1600
`define SAC_RC_CYCLES ((`SAC_RC_PERIOD_NS * 25) / 1000)
`endif

// [hw/sac_pkg.sv]
// Types shared by the converter control block.
// Assumes nothing beyond a SystemVerilog compiler.
package sac_pkg;
  // Conversion sequencer states
  typedef enum logic [1:0] {SAC_IDLE, SAC_WAIT, SAC_CONV} sac_state_e;
  // Positive reference choice presented to the analog side
  typedef enum logic [1:0] {SAC_VREF_SUPPLY, SAC_VREF_EXT, SAC_VREF_FIXED} sac_vref_e;
endpackage

// [hw/sac_tick_if.sv]
// Interface carrying the bit-period tick between divider and sequencer.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface sac_tick_if;
  logic [2:0] clk_sel; // Conversion clock select code
  logic restart; // Restart divider count
  logic run; // Divider allowed to count
  logic tick; // One-cycle bit-period enable
  modport src (input clk_sel, input restart, input run, output tick);
  modport dst (output clk_sel, output restart, output run, input tick);
endinterface
`default_nettype wire

// [hw/sac_clk_div.sv]
// Bit-period enable generator: divided system clock or RC period model.
// Assumes single system clock; RC source modelled by a fixed count.
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"
module sac_clk_div (
  input wire logic clk_i,
  input wire logic rst_i,
  sac_tick_if.src tk
);
  // ----------------------------------------------------------------------
  // Ratio decode
  // ----------------------------------------------------------------------
  logic [7:0] limit; // Cycles per bit period minus one
  logic [7:0] cnt_q; // Running divider count
  logic tick_q; // Registered tick

  // Low bits select 2/8/32, top bit doubles; x11 is the RC source
  always_comb begin
    case (tk.clk_sel[1:0])
      2'b00: limit = tk.clk_sel[2] ? 8'h03 : 8'h01;
      2'b01: limit = tk.clk_sel[2] ? 8'h0F : 8'h07;
      2'b10: limit = tk.clk_sel[2] ? 8'h3F : 8'h1F;
      default: limit = 8'((`SAC_RC_CYCLES) - 1); // RC period
    endcase
  end

  // ----------------------------------------------------------------------
  // Counter, restarted at conversion start
  // ----------------------------------------------------------------------
  // Non-RC ratios derive from the system clock so they follow it
  always_ff @(posedge clk_i) begin
    if (rst_i || tk.restart || !tk.run) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b1; // One-cycle pulse
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  assign tk.tick = tick_q;

  // Each tick lasts a single cycle
  property p_tick_single;
    @(posedge clk_i) disable iff (rst_i) tick_q |=> !tick_q;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick too long");
endmodule // sac_clk_div
`default_nettype wire

// [hw/sac_ctrl.sv]
// Successive-approximation converter control: registers, sequencer, irq.
// Assumes an analog comparator answering within the bit period and
// a register master with one-cycle strobes; one 25 MHz clock.
//
// Notes on behaviour
// - Eight-bit SAR result stored at completion
// - One sample-hold, only chosen input routed
// - Four-bit channel field picks the input
// - Reference: supply, external pin, fixed; ground negative
// - Clock: Fosc/2..64 codes or RC x11
// - Conversion lasts exactly ten bit periods
// - Non-RC clocks follow system clock
// - Done flag set every conversion regardless
// - Irq only when flag and enable set
// - Enabled irq works in sleep, wakes device
// - Runs in sleep only with RC clock
// - Enable first; start bit written separately
// - Completion clears busy, sets flag, loads result
// - Abort by clearing go stores partial, last bit filled
// - Codes 0-13 inputs, 14 reserved, 15 fixed
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"
module sac_ctrl (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic SLEEP_I,
  input wire logic CMP_I,
  output logic [13:0] CH_EN_O,
  output logic FIXED_REF_SEL_O,
  output logic [1:0] VREF_SEL_O,
  output logic SAMPLE_O,
  output logic [7:0] DAC_CODE_O,
  output logic IRQ_O,
  output logic WAKE_O
);
  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic converter_on_q; // Converter enabled
  logic go_q; // Conversion in progress bit
  logic [3:0] input_channel_sel_q; // Channel select
  logic [2:0] conv_clock_sel_q; // Conversion clock select
  logic [1:0] pos_reference_sel_q; // Positive reference select
  logic [7:0] conv_result_q; // Result register
  logic conv_done_flag_q; // Sticky completion flag
  logic conv_irq_enable_q; // Interrupt mask bit
  logic sleep_q; // Registered sleep level
  logic [7:0] sar_q; // Trial register
  logic [3:0] bit_cnt_q; // Bit periods elapsed
  logic [2:0] last_idx_q; // Index of last bit resolved
  logic any_res_q; // At least one bit resolved
  sac_pkg::sac_state_e state_q; // Sequencer state
  logic wr0, wr1, wr3, wr4, wr2; // Decoded writes
  logic go_wr1, go_wr0; // Software start/abort strobes
  logic rc_sel; // RC source selected
  logic halt; // Sleep aborts a non-RC conversion
  logic finish; // Tenth bit period reached
  logic [7:0] partial; // Abort result with fill
  logic [3:0] tally_q; // Bit periods counted for checking only
  sac_tick_if tk ();

  assign wr0 = WR_I && (ADDR_I == `SAC_OFS_CTRL0);
  assign wr1 = WR_I && (ADDR_I == `SAC_OFS_CTRL1);
  assign wr2 = WR_I && (ADDR_I == `SAC_OFS_RESULT);
  assign wr3 = WR_I && (ADDR_I == `SAC_OFS_IRQ_STAT);
  assign wr4 = WR_I && (ADDR_I == `SAC_OFS_IRQ_MASK);
  // Start only counts when the converter was already on
  assign go_wr1 = wr0 && WDATA_I[`SAC_CTRL0_GO_BIT] && converter_on_q;
  assign go_wr0 = wr0 && !WDATA_I[`SAC_CTRL0_GO_BIT];
  assign rc_sel = (conv_clock_sel_q[1:0] == 2'b11);
  assign halt = sleep_q && !rc_sel;
  assign finish = tk.tick && (state_q == sac_pkg::SAC_CONV)
    && (bit_cnt_q == `SAC_BIT_PERIODS - 4'h1);

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  assign tk.clk_sel = conv_clock_sel_q;
  assign tk.restart = go_wr1 && (state_q == sac_pkg::SAC_IDLE);
  assign tk.run = (state_q != sac_pkg::SAC_IDLE);
  sac_clk_div u_div (.clk_i(CLK_SYS_I), .rst_i(RST_I), .tk(tk));

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      converter_on_q <= 1'b0;
      input_channel_sel_q <= 4'h0;
      conv_clock_sel_q <= 3'h0;
      pos_reference_sel_q <= 2'h0;
      conv_irq_enable_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= SLEEP_I;
      if (wr0) begin
        converter_on_q <= WDATA_I[`SAC_CTRL0_ON_BIT];
        input_channel_sel_q <= WDATA_I[`SAC_CTRL0_CHS_LSB +: 4];
      end
      if (wr1) begin
        conv_clock_sel_q <= WDATA_I[`SAC_CTRL1_CS_LSB +: 3];
        pos_reference_sel_q <= WDATA_I[`SAC_CTRL1_REF_LSB +: 2];
      end
      if (wr4) begin
        conv_irq_enable_q <= WDATA_I[0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer: straight from start to ten bit periods, no wait period
  // ----------------------------------------------------------------------
  // The first period holds the sampled input, the next eight resolve bits MSB first,
  // the last one transfers; total ten periods.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state_q <= sac_pkg::SAC_IDLE;
      go_q <= 1'b0;
      bit_cnt_q <= 4'h0;
      sar_q <= 8'h00;
      last_idx_q <= 3'h7;
      any_res_q <= 1'b0;
    end else begin
      case (state_q)
        sac_pkg::SAC_IDLE: begin
          if (go_wr1) begin
            state_q <= sac_pkg::SAC_CONV;
            go_q <= 1'b1;
            bit_cnt_q <= 4'h0;
            sar_q <= 8'h80;
            any_res_q <= 1'b0;
          end
        end
        sac_pkg::SAC_CONV: begin
          if (go_wr0 || halt || !converter_on_q) begin
            state_q <= sac_pkg::SAC_IDLE; // Abort
            go_q <= 1'b0;
          end else if (tk.tick) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q >= 4'h1 && bit_cnt_q <= 4'h8) begin
              // Resolve bit 8-bit_cnt, then try next
              sar_q[3'(4'h8 - bit_cnt_q)] <= CMP_I;
              if (bit_cnt_q != 4'h8) begin
                sar_q[3'(4'h7 - bit_cnt_q)] <= 1'b1;
              end
              last_idx_q <= 3'(4'h8 - bit_cnt_q);
              any_res_q <= 1'b1;
            end
            if (finish) begin
              state_q <= sac_pkg::SAC_IDLE;
              go_q <= 1'b0;
            end
          end
        end
        default: state_q <= sac_pkg::SAC_IDLE;
      endcase
    end
  end

  // Unresolved bits take the value of the last resolved bit
  always_comb begin
    partial = sar_q;
    for (int i = 0; i < 8; i++) begin
      if (!any_res_q || 3'(i) < last_idx_q) begin
        partial[i] = any_res_q ? sar_q[last_idx_q] : 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Result and completion flag
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      conv_result_q <= `SAC_RST_BYTE;
    end else if (finish && !go_wr0 && !halt && converter_on_q) begin
      conv_result_q <= sar_q;
    end else if (state_q == sac_pkg::SAC_CONV && go_wr0) begin
      conv_result_q <= partial;
    end else if (wr2) begin
      conv_result_q <= WDATA_I;
    end
  end

  // Set wins over a write-one clear; hardware never clears it
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      conv_done_flag_q <= 1'b0;
    end else if (finish && !go_wr0 && !halt && converter_on_q) begin
      conv_done_flag_q <= 1'b1;
    end else if (wr3 && WDATA_I[0]) begin
      conv_done_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs to the analog side and interrupt
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      CH_EN_O <= 14'h0000;
      FIXED_REF_SEL_O <= 1'b0;
      VREF_SEL_O <= 2'h0;
      SAMPLE_O <= 1'b0;
      DAC_CODE_O <= 8'h00;
      IRQ_O <= 1'b0;
      WAKE_O <= 1'b0;
    end else begin
      // One-hot routing, nothing when off or reserved
      CH_EN_O <= 14'h0000;
      if (converter_on_q && input_channel_sel_q < `SAC_CHS_RESERVED) begin
        CH_EN_O[input_channel_sel_q] <= 1'b1;
      end
      FIXED_REF_SEL_O <= converter_on_q && (input_channel_sel_q == `SAC_CHS_FIXED_REF);
      case (pos_reference_sel_q)
        `SAC_REF_EXT: VREF_SEL_O <= 2'(sac_pkg::SAC_VREF_EXT);
        `SAC_REF_FIXED: VREF_SEL_O <= 2'(sac_pkg::SAC_VREF_FIXED);
        default: VREF_SEL_O <= 2'(sac_pkg::SAC_VREF_SUPPLY);
      endcase
      SAMPLE_O <= converter_on_q && (state_q == sac_pkg::SAC_IDLE);
      DAC_CODE_O <= sar_q;
      IRQ_O <= conv_done_flag_q && conv_irq_enable_q;
      WAKE_O <= conv_done_flag_q && conv_irq_enable_q && sleep_q;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      case (ADDR_I)
        `SAC_OFS_CTRL0: RDATA_O <= {2'b00, input_channel_sel_q, go_q, converter_on_q};
        `SAC_OFS_CTRL1: RDATA_O <= {1'b0, conv_clock_sel_q, 2'b00, pos_reference_sel_q};
        `SAC_OFS_RESULT: RDATA_O <= conv_result_q;
        `SAC_OFS_IRQ_STAT: RDATA_O <= {7'h00, conv_done_flag_q};
        `SAC_OFS_IRQ_MASK: RDATA_O <= {7'h00, conv_irq_enable_q};
        `SAC_OFS_MODE: RDATA_O <= {7'h00, sleep_q};
        default: RDATA_O <= 8'h00;
      endcase
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Check-only tally of bit periods, kept apart from the sequencer count so
  // that a slip in bit_cnt_q cannot hide from the length check
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || tk.restart) begin
      tally_q <= 4'h0; // Fresh count per conversion
    end else if (tk.tick && state_q == sac_pkg::SAC_CONV) begin
      tally_q <= tally_q + 4'h1;
    end
  end

  property p_done_sets;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      finish && !go_wr0 && !halt && converter_on_q |=> conv_done_flag_q && !go_q;
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("flag not set at completion");
  property p_no_hw_clear;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      conv_done_flag_q && !(wr3 && WDATA_I[0]) |=> conv_done_flag_q;
  endproperty
  a_no_hw_clear: assert property (p_no_hw_clear) else $error("flag cleared by hardware");
  property p_irq;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      ##1 IRQ_O == $past(conv_done_flag_q && conv_irq_enable_q);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_wake;
    @(posedge CLK_SYS_I) disable iff (RST_I) WAKE_O |-> IRQ_O;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without irq");
  property p_sleep_halt;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      halt && state_q == sac_pkg::SAC_CONV |=> state_q == sac_pkg::SAC_IDLE;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("conversion kept running");
  property p_start_needs_on;
    @(posedge CLK_SYS_I) disable iff (RST_I) $rose(go_q) |-> $past(converter_on_q);
  endproperty
  a_start_needs_on: assert property (p_start_needs_on) else $error("start while off");
  property p_one_hot;
    @(posedge CLK_SYS_I) disable iff (RST_I) $onehot0({CH_EN_O, FIXED_REF_SEL_O});
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("more than one input routed");
  property p_ten;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      $rose(conv_done_flag_q) |-> tally_q == `SAC_BIT_PERIODS;
  endproperty
  a_ten: assert property (p_ten) else $error("conversion not ten periods");
  property p_result;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      finish && !go_wr0 && !halt && converter_on_q |=> conv_result_q == $past(sar_q);
  endproperty
  a_result: assert property (p_result) else $error("result not loaded");
  // The reserved channel code must leave the mux fully open
  property p_reserved;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      input_channel_sel_q == `SAC_CHS_RESERVED |=> CH_EN_O == 14'h0000 && !FIXED_REF_SEL_O;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code routed an input");
endmodule // sac_ctrl
`default_nettype wire

// [sim/sac_analog_model.sv]
// Behavioural model of the analog side: input mux, sample-hold, comparator.
// Assumes the control block's outputs are registered on the system clock.
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model #(
  parameter logic [7:0] FIXED_LVL = 8'h80 // Level seen on the fixed reference route
) (
  input wire logic clk_i,
  input wire logic [13:0] ch_en_i,
  input wire logic fixed_sel_i,
  input wire logic sample_i,
  input wire logic [7:0] dac_code_i,
  output logic cmp_o
);
  // --------------------------------------------------------------
  // Input mux and hold
  // --------------------------------------------------------------
  logic [7:0] in_lvl; // Level at the mux output
  logic [7:0] held_q; // Level on the hold capacitor
  logic [7:0] float_q = 8'h55; // Undriven mux output wanders every cycle

  // An unrouted mux must not look like a stable channel
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q;
  end

  // Only the routed input reaches the hold stage
  always_comb begin
    in_lvl = float_q;
    for (int i = 0; i < 14; i++) begin
      if (ch_en_i[i]) begin
        in_lvl = 8'(16 * i + 9);
      end
    end
    if (fixed_sel_i) begin
      in_lvl = FIXED_LVL;
    end
  end

  // Track while sampling, hold while converting
  always_ff @(posedge clk_i) begin
    if (sample_i) begin
      held_q <= in_lvl;
    end
  end

  // Reference choice only scales full range, so codes compare directly
  assign cmp_o = (held_q >= dac_code_i);
endmodule // sac_analog_model
`default_nettype wire

// [sim/adc_sar_control_tb_top.sv]
// Self-checking bench for the converter control block.
// Assumes the analog model in sim/ and the design sources in hw/.
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, (act), (exp)); end end
module adc_sar_control_tb_top;
  // --------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------
  logic clk = 1'b0; // 25 MHz system clock
  logic rst; // Synchronous reset
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic sleep; // Device sleep level
  logic [7:0] rdata;
  logic cmp;
  logic [13:0] ch_en;
  logic fixed_sel;
  logic [1:0] vref_sel;
  logic sample;
  logic [7:0] dac_code;
  logic irq;
  logic wake;
  int n_mismatch = 0;
  int comparisons = 0;

  sac_ctrl dut_u (.CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .SLEEP_I(sleep), .CMP_I(cmp), .CH_EN_O(ch_en),
    .FIXED_REF_SEL_O(fixed_sel), .VREF_SEL_O(vref_sel), .SAMPLE_O(sample),
    .DAC_CODE_O(dac_code), .IRQ_O(irq), .WAKE_O(wake));
  sac_analog_model ana_u (.clk_i(clk), .ch_en_i(ch_en), .fixed_sel_i(fixed_sel),
    .sample_i(sample), .dac_code_i(dac_code), .cmp_o(cmp));

  always #20 clk = ~clk;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Channel level as the analog model presents it
  function automatic logic [7:0] ch_val(input int c);
    return 8'(16 * c + 9);
  endfunction
  // Partial result: k top bits kept, the rest copy the last kept bit
  function automatic logic [7:0] partial(input logic [7:0] v, input int k);
    partial = v;
    for (int b = 7 - k; b >= 0; b--) partial[b] = v[8 - k];
  endfunction
  // One-cycle write strobe
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read and compare; data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Wait for the interrupt line under a bound, return cycles spent
  task automatic wait_irq(output int cnt);
    cnt = 0;
    while (irq !== 1'b1 && cnt < 2000) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask
  // Select clock and channel, allow acquisition, then start
  task automatic start(input logic [2:0] cs, input logic [3:0] ch);
    wrr(4'h1, {1'b0, cs, 4'h0});
    wrr(4'h0, {2'b00, ch, 2'b01});
    cycles(4); // Acquisition delay after a channel change
    wrr(4'h0, {2'b00, ch, 2'b11}); // Start in a write of its own
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    for (int a = 0; a < 8; a++) rdc(4'(a), 8'h00); // Reset values, unmapped reads zero
    `CHK({ch_en, fixed_sel, vref_sel, sample, dac_code, irq, wake}, 28'h000_0000)
  endtask
  task automatic t_regs;
    wrr(4'h0, 8'hFF);
    rdc(4'h0, 8'h3D); // Start ignored when the same write enables
    rdc(4'h3, 8'h00);
    wrr(4'h1, 8'hFF);
    rdc(4'h1, 8'h73);
    wrr(4'h2, 8'h5A);
    rdc(4'h2, 8'h5A);
  endtask
  task automatic t_route;
    for (int c = 0; c < 16; c++) begin
      wrr(4'h0, {2'b00, 4'(c), 2'b01});
      cycles(2);
      `CHK(ch_en, (c < 14) ? 14'(1 << c) : 14'h0000)
      `CHK(fixed_sel, (c == 15))
    end
  endtask
  task automatic t_ref;
    for (int r = 0; r < 4; r++) begin
      wrr(4'h1, {6'h00, 2'(r)});
      cycles(2);
      `CHK(vref_sel, (r > 1) ? 2'(r - 1) : 2'h0)
    end
  endtask
  task automatic t_clocks;
    int cnt;
    int n [8] = '{2, 8, 32, 40, 4, 16, 64, 40};
    wrr(4'h4, 8'h01);
    for (int cs = 0; cs < 8; cs++) begin
      start(3'(cs), 4'(cs + 3));
      // The RC source is only used for a conversion that runs in sleep
      sleep <= (cs[1:0] == 2'b11);
      wait_irq(cnt);
      `CHK(cnt >= 10 * n[cs] - 1 && cnt <= 10 * n[cs] + 3, 1'b1)
      `CHK(wake, (cs[1:0] == 2'b11))
      rdc(4'h2, ch_val(cs + 3));
      rdc(4'h0, {2'b00, 4'(cs + 3), 2'b01});
      rdc(4'h3, 8'h01);
      wrr(4'h3, 8'h01);
      sleep <= 1'b0;
    end
  endtask
  task automatic t_flag;
    wrr(4'h4, 8'h00);
    start(3'b000, 4'h2);
    cycles(40);
    `CHK(irq, 1'b0)
    wrr(4'h3, 8'h00);
    cycles(50);
    rdc(4'h3, 8'h01); // Flag set while masked and held
    wrr(4'h4, 8'h01);
    cycles(2);
    `CHK(irq, 1'b1)
    wrr(4'h3, 8'h01);
    cycles(2);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_abort;
    start(3'b110, 4'hB);
    cycles(348);
    wrr(4'h0, {2'b00, 4'hB, 2'b01});
    cycles(8);
    rdc(4'h2, partial(ch_val(11), 4));
    rdc(4'h3, 8'h00);
  endtask
  task automatic t_sleep;
    int cnt;
    start(3'b001, 4'h7);
    cycles(19);
    @(posedge clk);
    sleep <= 1'b1;
    cycles(200);
    rdc(4'h5, 8'h01);
    rdc(4'h0, {2'b00, 4'h7, 2'b01}); // Sleep stopped it and cleared busy
    rdc(4'h3, 8'h00); // Non-RC clock stops in sleep
    rdc(4'h2, partial(ch_val(11), 4));
    @(posedge clk);
    sleep <= 1'b0;
    start(3'b111, 4'h7);
    sleep <= 1'b1;
    wait_irq(cnt);
    cycles(1);
    `CHK(wake, 1'b1)
    rdc(4'h2, ch_val(7));
    wrr(4'h3, 8'h01);
    sleep <= 1'b0;
  endtask

  // --------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Bound well above the few thousand cycles the sequence needs
  initial begin
    #(40 * 20000);
    n_mismatch++;
    complete_run();
  end

  initial begin
    {rst, addr, wdata, wr, rd, sleep} = {1'b1, 4'h0, 8'h00, 3'b000};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_route();
    t_ref();
    t_clocks();
    t_flag();
    t_abort();
    t_sleep();
    complete_run();
  end
endmodule // adc_sar_control_tb_top
`default_nettype wire
